//--- hdl/svms_params.svh
// Constants for the servo mode sequencer: offsets, fields, reset values
// Overview of operation
// - On-line latch sets with plug present and servo data, or during recal.
// - Recalibration keeps the drive on line even without servo data.
// - On-line latch clears on plug removal or servo loss outside recal.
// - 815 cylinders; any cylinder difference up to 814 is accepted.
// - Velocity mode while seeking, rezeroing, loading or unloading heads.
// - Position mode while track following, centred or offset.
// - Head loading starts only after disc speed is reached.
// - Loading drives the motor forward until heads are over cylinder 000.
// - Loaded heads switch the servo from velocity to position mode.
// - Retract drives the motor in reverse until carriage is fully out.
// - Retract starts on operator power-down or a servo fault.
// - Recal starts on controller command or plug reinsertion.
// - Recal first reverses until heads leave the cylinder area.
// - Recal then drives forward until heads are over cylinder 000.
// - Finished recalibration switches to position mode.
// - Each cylinder crossed in a seek decrements the difference count.
// - Seek ends and heads stop when the difference count reaches zero.
// - Count-zero indication rises about one track before the target.
// - Position mode only follows a velocity operation that placed heads.
// - Position mode follows centreline or offset as the controller asks.
// - No controller or host action can start a retract.
`ifndef SVMS_PARAMS_SVH
`define SVMS_PARAMS_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define SVMS_ADDR_SEEK    4'h0
`define SVMS_ADDR_OFFSET  4'h1
`define SVMS_ADDR_CMD     4'h2
`define SVMS_ADDR_STATUS  4'h3
`define SVMS_ADDR_COUNT   4'h4
// ----------------------------------------
// Field positions
// ----------------------------------------
`define SVMS_CMD_SEEK     0
`define SVMS_CMD_RECAL    1
`define SVMS_CMD_OFS_GO   2
`define SVMS_CMD_OFS_CLR  3
`define SVMS_SEEK_DIR     15
`define SVMS_OFS_DIR      8
`define SVMS_ST_ONLINE    0
`define SVMS_ST_VEL       1
`define SVMS_ST_POS       2
`define SVMS_ST_ZERO      3
`define SVMS_ST_OFS       4
`define SVMS_ST_RPEND     5
`define SVMS_ST_STATE     8
// ----------------------------------------
// Sizes and reset values
// ----------------------------------------
`define SVMS_CYL_W        10
`define SVMS_CYL_COUNT    815
`define SVMS_MAX_DIFF     10'h32e
`define SVMS_DIFF_RST     10'h000
`define SVMS_OFS_RST      8'h00
`define SVMS_RD_ZERO      16'h0000
`endif

//--- hdl/svms_pkg.sv
// Types shared by the servo mode sequencer
package svms_pkg;
  typedef enum logic [2:0] {
    SVMS_UNLOADED  = 3'b000,
    SVMS_LOAD      = 3'b001,
    SVMS_FOLLOW    = 3'b010,
    SVMS_SEEK      = 3'b011,
    SVMS_RECAL_REV = 3'b100,
    SVMS_RECAL_FWD = 3'b101,
    SVMS_RETRACT   = 3'b110
  } svms_state_t;
  // Drive sense lines, all synchronous to clk_i
  typedef struct packed {
    logic logical_address_plug;
    logic servo_data;
    logic speed_ok;
    logic power_down;
    logic servo_fault;
    logic cyl_pulse;
    logic at_cyl0;
    logic out_of_area;
    logic retracted;
  } svms_sense_t;
  typedef struct packed {
    logic       dir;
    logic [9:0] diff;
  } svms_seek_arg_t;
  typedef struct packed {
    logic       dir;
    logic [7:0] amount;
  } svms_offset_t;
endpackage

//--- hdl/svms_cyl_counter.sv
// Cylinder difference down-counter with early zero indication
`include "svms_params.svh"
module svms_cyl_counter (
  input  wire logic                   clk_i,
  input  wire logic                   resetn_i,
  input  wire logic                   load_i,
  input  wire logic [`SVMS_CYL_W-1:0] diff_i,
  input  wire logic                   dec_i,
  output logic      [`SVMS_CYL_W-1:0] count_o,
  output logic                        near_zero_o
);
  import svms_pkg::*;
  logic [`SVMS_CYL_W-1:0] count_ff;
  logic [`SVMS_CYL_W-1:0] nxt_count;
  logic                   near_ff;
  logic                   nxt_near;
  // ----------------------------------------
  // Next count
  // ----------------------------------------
  // Load, decrement above zero, else hold
  assign nxt_count = load_i ? diff_i :
                     (dec_i && count_ff != '0) ?
                     count_ff - 10'h001 : count_ff;
  // Flag one cylinder ahead of the target
  assign nxt_near = (nxt_count <= 10'h001);
  // Counter and flag registers
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      count_ff <= `SVMS_DIFF_RST;
      near_ff  <= 1'b1;
    end
    else
    begin
      count_ff <= nxt_count;
      near_ff  <= nxt_near;
    end
  end
  assign count_o     = count_ff;
  assign near_zero_o = near_ff;
  // ----------------------------------------
  // Checks
  // ----------------------------------------
  chk_count_dec: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    dec_i && !load_i && count_ff != '0
    |=> count_ff == $past(count_ff) - 10'h001)
    else $error("count did not step down");
  chk_count_hold: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    !dec_i && !load_i |=> $stable(count_ff))
    else $error("count moved without a seek");
endmodule

//--- hdl/svms_seq.sv
// Servo mode sequencer: on-line latch, mode control and seek sequencing
`include "svms_params.svh"
module svms_seq (
  input  wire logic                 clk_i,
  input  wire logic                 resetn_i,
  input  wire svms_pkg::svms_sense_t sense_i,
  input  wire logic [3:0]           reg_addr_i,
  input  wire logic [15:0]          reg_wdata_i,
  input  wire logic                 reg_we_i,
  input  wire logic                 reg_re_i,
  output logic      [15:0]          reg_rdata_o,
  output logic                      online_o,
  output logic                      velocity_mode_o,
  output logic                      position_mode_o,
  output logic                      vcm_fwd_o,
  output logic                      vcm_rev_o,
  output logic                      cylinder_count_zero_o,
  output logic                      offset_active_o,
  output svms_pkg::svms_offset_t    offset_o
);
  import svms_pkg::*;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!resetn_i);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  svms_state_t            state_ff;
  svms_state_t            nxt_state;
  svms_seek_arg_t         seek_arg_ff;
  svms_seek_arg_t         nxt_seek_arg;
  svms_offset_t           offset_ff;
  svms_offset_t           nxt_offset;
  logic                   seek_dir_ff;
  logic                   nxt_seek_dir;
  logic                   plug_prev_ff;
  logic                   recal_pend_ff;
  logic                   nxt_recal_pend;
  logic                   online_ff;
  logic                   nxt_online;
  logic                   vel_ff;
  logic                   nxt_vel;
  logic                   pos_ff;
  logic                   nxt_pos;
  logic                   fwd_ff;
  logic                   nxt_fwd;
  logic                   rev_ff;
  logic                   nxt_rev;
  logic                   ofs_act_ff;
  logic                   nxt_ofs_act;
  logic [15:0]            rdata_ff;
  logic [15:0]            nxt_rdata;
  logic [15:0]            rd_mux;
  logic [15:0]            status_word;
  logic [`SVMS_CYL_W-1:0] count;
  logic [`SVMS_CYL_W-1:0] wr_diff;
  logic                   near_zero;
  logic                   sel_seek;
  logic                   sel_ofs;
  logic                   sel_cmd;
  logic                   sel_status;
  logic                   sel_count;
  logic                   cmd_wr;
  logic                   seek_cmd;
  logic                   recal_cmd;
  logic                   ofs_go;
  logic                   ofs_clr;
  logic                   plug_rise;
  logic                   retract_req;
  logic                   recal_go;
  logic                   seek_start;
  logic                   recal_active;
  logic                   in_follow;
  logic                   seek_dec;

  // ----------------------------------------
  // Register decode
  // ----------------------------------------
  // Address selects
  assign sel_seek   = (reg_addr_i == `SVMS_ADDR_SEEK);
  assign sel_ofs    = (reg_addr_i == `SVMS_ADDR_OFFSET);
  assign sel_cmd    = (reg_addr_i == `SVMS_ADDR_CMD);
  assign sel_status = (reg_addr_i == `SVMS_ADDR_STATUS);
  assign sel_count  = (reg_addr_i == `SVMS_ADDR_COUNT);

  // Command strobes, one cycle each
  assign cmd_wr    = reg_we_i && sel_cmd;
  assign seek_cmd  = cmd_wr && reg_wdata_i[`SVMS_CMD_SEEK];
  assign recal_cmd = cmd_wr && reg_wdata_i[`SVMS_CMD_RECAL];
  assign ofs_go    = cmd_wr && reg_wdata_i[`SVMS_CMD_OFS_GO];
  assign ofs_clr   = cmd_wr && reg_wdata_i[`SVMS_CMD_OFS_CLR];

  // Clamp difference to the last reachable cylinder
  assign wr_diff = (reg_wdata_i[9:0] > `SVMS_MAX_DIFF) ?
                   `SVMS_MAX_DIFF : reg_wdata_i[9:0];

  // Seek argument store
  assign nxt_seek_arg = (reg_we_i && sel_seek) ?
                        {reg_wdata_i[`SVMS_SEEK_DIR], wr_diff} :
                        seek_arg_ff;

  // Offset amount store
  assign nxt_offset = (reg_we_i && sel_ofs) ?
                      reg_wdata_i[8:0] : offset_ff;

  // Status word
  assign status_word = {5'h00,
                        state_ff,
                        2'b00,
                        recal_pend_ff,
                        ofs_act_ff,
                        near_zero,
                        pos_ff,
                        vel_ff,
                        online_ff};

  // Read selection, unmapped and command read as zero
  assign rd_mux =
    sel_seek   ? {seek_arg_ff.dir, 5'h00, seek_arg_ff.diff} :
    sel_ofs    ? {7'h00, offset_ff} :
    sel_status ? status_word :
    sel_count  ? {6'h00, count} :
    `SVMS_RD_ZERO;
  assign nxt_rdata = reg_re_i ? rd_mux : `SVMS_RD_ZERO;

  // Register file and read data
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      seek_arg_ff <= {1'b0, `SVMS_DIFF_RST};
      offset_ff   <= {1'b0, `SVMS_OFS_RST};
      rdata_ff    <= `SVMS_RD_ZERO;
    end
    else
    begin
      seek_arg_ff <= nxt_seek_arg;
      offset_ff   <= nxt_offset;
      rdata_ff    <= nxt_rdata;
    end
  end

  // ----------------------------------------
  // Sequencing conditions
  // ----------------------------------------
  // Only internal faults or operator power-down
  assign retract_req = sense_i.power_down ||
                       sense_i.servo_fault;
  assign plug_rise   = sense_i.logical_address_plug &&
                       !plug_prev_ff;
  assign recal_go    = recal_cmd || plug_rise ||
                       recal_pend_ff;
  assign in_follow   = (state_ff == SVMS_FOLLOW);
  assign seek_start  = in_follow && !retract_req &&
                       !recal_go && seek_cmd;
  assign recal_active = (state_ff == SVMS_RECAL_REV) ||
                        (state_ff == SVMS_RECAL_FWD);
  assign seek_dec    = (state_ff == SVMS_SEEK) &&
                       sense_i.cyl_pulse;

  // ----------------------------------------
  // State machine
  // ----------------------------------------
  // Next state
  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      SVMS_UNLOADED:
        if (sense_i.speed_ok && !retract_req)
          nxt_state = SVMS_LOAD;
      SVMS_LOAD:
        if (retract_req)
          nxt_state = SVMS_RETRACT;
        else if (sense_i.at_cyl0)
          nxt_state = SVMS_FOLLOW;
      SVMS_FOLLOW:
        if (retract_req)
          nxt_state = SVMS_RETRACT;
        else if (recal_go)
          nxt_state = SVMS_RECAL_REV;
        else if (seek_cmd)
          nxt_state = SVMS_SEEK;
      SVMS_SEEK:
        if (retract_req)
          nxt_state = SVMS_RETRACT;
        else if (count == '0)
          nxt_state = SVMS_FOLLOW;
      SVMS_RECAL_REV:
        if (retract_req)
          nxt_state = SVMS_RETRACT;
        else if (sense_i.out_of_area)
          nxt_state = SVMS_RECAL_FWD;
      SVMS_RECAL_FWD:
        if (retract_req)
          nxt_state = SVMS_RETRACT;
        else if (sense_i.at_cyl0)
          nxt_state = SVMS_FOLLOW;
      SVMS_RETRACT:
        if (sense_i.retracted)
          nxt_state = SVMS_UNLOADED;
      default:
        nxt_state = SVMS_RETRACT;
    endcase
  end

  // Pending recal survives until the sequence begins; set wins
  assign nxt_recal_pend = recal_cmd || plug_rise ||
                          (recal_pend_ff &&
                           nxt_state != SVMS_RECAL_REV);

  // Seek direction caught at seek start
  assign nxt_seek_dir = seek_start ? seek_arg_ff.dir : seek_dir_ff;

  // ----------------------------------------
  // Outputs from next state, on-line latch from current state
  // ----------------------------------------
  // On-line latch
  assign nxt_online = sense_i.logical_address_plug &&
                      (sense_i.servo_data ||
                       recal_active);

  // Mode selection
  assign nxt_pos = (nxt_state == SVMS_FOLLOW);
  assign nxt_vel = (nxt_state != SVMS_FOLLOW) &&
                   (nxt_state != SVMS_UNLOADED);

  // Motor drive direction
  assign nxt_fwd = (nxt_state == SVMS_LOAD) ||
                   (nxt_state == SVMS_RECAL_FWD) ||
                   (nxt_state == SVMS_SEEK && !nxt_seek_dir);
  assign nxt_rev = (nxt_state == SVMS_RETRACT) ||
                   (nxt_state == SVMS_RECAL_REV) ||
                   (nxt_state == SVMS_SEEK && nxt_seek_dir);

  // Offset following only while staying in track follow; go beats clear
  assign nxt_ofs_act = in_follow && (nxt_state == SVMS_FOLLOW) &&
                       (ofs_go || (ofs_act_ff && !ofs_clr));

  // Sequencer registers
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      state_ff      <= SVMS_UNLOADED;
      seek_dir_ff   <= 1'b0;
      plug_prev_ff  <= 1'b0;
      recal_pend_ff <= 1'b0;
    end
    else
    begin
      state_ff      <= nxt_state;
      seek_dir_ff   <= nxt_seek_dir;
      plug_prev_ff  <= sense_i.logical_address_plug;
      recal_pend_ff <= nxt_recal_pend;
    end
  end

  // Output registers
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      online_ff  <= 1'b0;
      vel_ff     <= 1'b0;
      pos_ff     <= 1'b0;
      fwd_ff     <= 1'b0;
      rev_ff     <= 1'b0;
      ofs_act_ff <= 1'b0;
    end
    else
    begin
      online_ff  <= nxt_online;
      vel_ff     <= nxt_vel;
      pos_ff     <= nxt_pos;
      fwd_ff     <= nxt_fwd;
      rev_ff     <= nxt_rev;
      ofs_act_ff <= nxt_ofs_act;
    end
  end

  // ----------------------------------------
  // Difference counter
  // ----------------------------------------
  svms_cyl_counter u_cnt (
    .clk_i       (clk_i),
    .resetn_i    (resetn_i),
    .load_i      (seek_start),
    .diff_i      (seek_arg_ff.diff),
    .dec_i       (seek_dec),
    .count_o     (count),
    .near_zero_o (near_zero)
  );

  // Port drive
  assign reg_rdata_o           = rdata_ff;
  assign online_o              = online_ff;
  assign velocity_mode_o       = vel_ff;
  assign position_mode_o       = pos_ff;
  assign vcm_fwd_o             = fwd_ff;
  assign vcm_rev_o             = rev_ff;
  assign cylinder_count_zero_o = near_zero;
  assign offset_active_o       = ofs_act_ff;
  assign offset_o              = offset_ff;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence s_recal_rev;
    state_ff == SVMS_RECAL_REV && sense_i.out_of_area && !retract_req;
  endsequence
  sequence s_recal_fwd;
    state_ff == SVMS_RECAL_FWD && sense_i.at_cyl0 && !retract_req;
  endsequence

  chk_online_set: assert property (
    sense_i.logical_address_plug && sense_i.servo_data |=> online_o)
    else $error("on-line not set");
  chk_online_recal: assert property (
    sense_i.logical_address_plug && recal_active |=> online_o)
    else $error("on-line dropped in recal");
  chk_online_clear: assert property (
    !sense_i.logical_address_plug ||
    (!sense_i.servo_data && !recal_active) |=> !online_o)
    else $error("on-line not cleared");
  chk_velocity_mode: assert property (
    state_ff inside {SVMS_LOAD, SVMS_SEEK, SVMS_RETRACT,
                     SVMS_RECAL_REV, SVMS_RECAL_FWD}
    |-> velocity_mode_o && !position_mode_o)
    else $error("not in velocity mode");
  chk_position_mode: assert property (
    state_ff == SVMS_FOLLOW |-> position_mode_o && !velocity_mode_o)
    else $error("not in position mode");
  chk_load_speed: assert property (
    $rose(state_ff == SVMS_LOAD) |-> $past(sense_i.speed_ok))
    else $error("load before speed");
  chk_load_forward: assert property (
    state_ff == SVMS_LOAD |-> vcm_fwd_o && !vcm_rev_o)
    else $error("load not forward");
  chk_load_done: assert property (
    state_ff == SVMS_LOAD && sense_i.at_cyl0 && !retract_req
    |=> position_mode_o)
    else $error("load did not end in follow");
  chk_retract_drive: assert property (
    state_ff == SVMS_RETRACT |-> vcm_rev_o && !vcm_fwd_o)
    else $error("retract not reverse");
  chk_retract_start: assert property (
    retract_req && state_ff != SVMS_UNLOADED && !sense_i.retracted
    |=> state_ff == SVMS_RETRACT [*1] ##0 velocity_mode_o)
    else $error("retract not started");
  chk_recal_start: assert property (
    in_follow && recal_cmd && !retract_req
    |=> state_ff == SVMS_RECAL_REV ##0 vcm_rev_o)
    else $error("recal not started");
  chk_recal_phase: assert property (
    s_recal_rev |=> state_ff == SVMS_RECAL_FWD ##0 vcm_fwd_o)
    else $error("recal reverse phase wrong");
  chk_recal_done: assert property (
    s_recal_fwd |=> position_mode_o && !vcm_fwd_o && !vcm_rev_o)
    else $error("recal did not finish");
  chk_seek_end: assert property (
    state_ff == SVMS_SEEK && count == '0 && !retract_req
    |=> state_ff == SVMS_FOLLOW && !vcm_fwd_o && !vcm_rev_o)
    else $error("seek did not stop");
  chk_zero_early: assert property (
    state_ff == SVMS_SEEK && count == 10'h001
    |-> cylinder_count_zero_o)
    else $error("count zero late");
  chk_offset_go: assert property (
    in_follow && ofs_go && nxt_state == SVMS_FOLLOW
    |=> offset_active_o [*1])
    else $error("offset not started");
  chk_no_host_retract: assert property (
    !retract_req && state_ff != SVMS_RETRACT
    |=> state_ff != SVMS_RETRACT)
    else $error("retract without fault");
endmodule

//--- bench/svms_dcl_model.sv
// Disc controller model driving the sequencer register port
`include "svms_params.svh"
module svms_dcl_model (
  input  wire logic        clk_i,
  input  wire logic [15:0] reg_rdata_i,
  output logic      [3:0]  reg_addr_o,
  output logic      [15:0] reg_wdata_o,
  output logic             reg_we_o,
  output logic             reg_re_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // Idle bus at time zero
  initial
  begin
    reg_addr_o  = 4'h0;
    reg_wdata_o = 16'h0;
    reg_we_o    = 1'b0;
    reg_re_o    = 1'b0;
  end
  // One-cycle write, stale data inverted once taken
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_i);
    reg_addr_o  <= a;
    reg_wdata_o <= d;
    reg_we_o    <= 1'b1;
    @(posedge clk_i);
    reg_we_o    <= 1'b0;
    reg_wdata_o <= ~d;
  endtask
  // One-cycle read, data taken at the edge that closes the data cycle
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk_i);
    reg_addr_o <= a;
    reg_re_o   <= 1'b1;
    @(posedge clk_i);
    reg_re_o   <= 1'b0;
    @(posedge clk_i);
    d = reg_rdata_i;
  endtask
  // Seek argument first, then the seek command
  task automatic seek(input logic dir, input logic [9:0] dif);
    wr(`SVMS_ADDR_SEEK, {dir, 5'h0, dif});
    wr(`SVMS_ADDR_CMD, 16'h0001);
  endtask
  // Offset amount first, then offset start
  task automatic offset(input logic [8:0] o);
    wr(`SVMS_ADDR_OFFSET, {7'h0, o});
    wr(`SVMS_ADDR_CMD, 16'h0004);
  endtask
endmodule

//--- bench/svms_seq_tb.sv
// Self-checking bench for the servo mode sequencer
`include "svms_params.svh"
module svms_seq_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import svms_pkg::*;
  logic         clk_i    = 1'b0;
  logic         resetn_i = 1'b0;
  svms_sense_t  sense    = '0;
  logic [3:0]   addr;
  logic [15:0]  wdata;
  logic [15:0]  rdata;
  logic         we;
  logic         re;
  logic [3:0]   mode;
  logic         online;
  logic         czero;
  logic         ofs_act;
  svms_offset_t ofs;
  logic [15:0]  v;
  logic [9:0]   dif;
  logic         dir;
  logic [8:0]   ov;
  int           k;
  int           bad_count  = 0;
  int           n_compared = 0;

  always #4 clk_i = ~clk_i;

  svms_seq u_dut (.clk_i(clk_i), .resetn_i(resetn_i), .sense_i(sense),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_we_i(we), .reg_re_i(re),
    .reg_rdata_o(rdata), .online_o(online), .velocity_mode_o(mode[3]),
    .position_mode_o(mode[2]), .vcm_fwd_o(mode[1]), .vcm_rev_o(mode[0]),
    .cylinder_count_zero_o(czero), .offset_active_o(ofs_act),
    .offset_o(ofs));
  svms_dcl_model u_dcl (.clk_i(clk_i), .reg_rdata_i(rdata),
    .reg_addr_o(addr), .reg_wdata_o(wdata), .reg_we_o(we), .reg_re_o(re));

  // ----------------------------------------
  // Checking helpers
  // ----------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    $display("compared=%0d mismatches=%0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Expected {velocity, position, forward, reverse} per state
  function automatic logic [3:0] mexp(svms_state_t s, logic d);
    mexp[3] = !(s inside {SVMS_FOLLOW, SVMS_UNLOADED});
    mexp[2] = (s == SVMS_FOLLOW);
    mexp[1] = (s inside {SVMS_LOAD, SVMS_RECAL_FWD}) || (s == SVMS_SEEK && !d);
    mexp[0] = (s inside {SVMS_RETRACT, SVMS_RECAL_REV}) ||
              (s == SVMS_SEEK && d);
  endfunction
  // Poll status until state matches, then check state and modes
  task automatic wait_st(input svms_state_t s, input logic d);
    logic [15:0] r;
    for (int i = 0; i < 40; i++)
    begin
      u_dcl.rd(`SVMS_ADDR_STATUS, r);
      if (r[10:8] === s)
        break;
    end
    chk({13'h0, r[10:8]}, {13'h0, s});
    chk({12'h0, mode}, {12'h0, mexp(s, d)});
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // Watchdog
  initial
  begin
    #200000;
    bad_count++;
    close_out();
  end

  // Main sequence
  initial
  begin
    void'($urandom(56997));
    repeat (2) @(posedge clk_i);
    resetn_i <= 1'b1;
    sense.logical_address_plug <= 1'b1;
    sense.servo_data <= 1'b1;
    wait_st(SVMS_UNLOADED, 1'b0);
    sense.speed_ok <= 1'b1;
    wait_st(SVMS_LOAD, 1'b0);
    sense.at_cyl0 <= 1'b1;
    wait_st(SVMS_RECAL_REV, 1'b0);
    sense.servo_data <= 1'b0;
    step(3);
    chk({15'h0, online}, 16'h0001);
    sense.at_cyl0 <= 1'b0;
    sense.out_of_area <= 1'b1;
    wait_st(SVMS_RECAL_FWD, 1'b0);
    sense.out_of_area <= 1'b0;
    sense.at_cyl0 <= 1'b1;
    wait_st(SVMS_FOLLOW, 1'b0);
    step(3);
    chk({15'h0, online}, 16'h0000);
    sense.servo_data <= 1'b1;
    step(3);
    chk({15'h0, online}, 16'h0001);
    for (k = 0; k < 6; k++)
    begin
      dif = (k == 0) ? 10'h3ff : (k == 1) ? 10'h0 : 10'($urandom_range(1, 24));
      dir = 1'($urandom);
      u_dcl.seek(dir, dif);
      if (dif > `SVMS_MAX_DIFF)
        dif = `SVMS_MAX_DIFF;
      u_dcl.rd(`SVMS_ADDR_SEEK, v);
      chk(v, {dir, 5'h0, dif});
      while (dif != 10'h0)
      begin
        u_dcl.rd(`SVMS_ADDR_COUNT, v);
        chk(v, {6'h0, dif});
        chk({15'h0, czero}, {15'h0, dif <= 10'h1});
        chk({12'h0, mode}, {12'h0, mexp(SVMS_SEEK, dir)});
        sense.cyl_pulse <= 1'b1;
        @(posedge clk_i);
        sense.cyl_pulse <= 1'b0;
        dif = dif - 10'h1;
      end
      wait_st(SVMS_FOLLOW, 1'b0);
      sense.cyl_pulse <= 1'b1;
      @(posedge clk_i);
      sense.cyl_pulse <= 1'b0;
      u_dcl.rd(`SVMS_ADDR_COUNT, v);
      chk(v, 16'h0000);
    end
    ov = 9'($urandom);
    u_dcl.offset(ov);
    step(1);
    chk({6'h0, ofs_act, ofs}, {7'h1, ov});
    u_dcl.wr(`SVMS_ADDR_CMD, 16'h0008);
    step(1);
    chk({15'h0, ofs_act}, 16'h0000);
    u_dcl.wr(`SVMS_ADDR_CMD, 16'hfff0);
    u_dcl.wr(`SVMS_ADDR_STATUS, 16'hffff);
    u_dcl.wr(4'hf, 16'hffff);
    u_dcl.rd(4'hf, v);
    chk(v, 16'h0000);
    wait_st(SVMS_FOLLOW, 1'b0);
    u_dcl.wr(`SVMS_ADDR_CMD, 16'h0002);
    wait_st(SVMS_RECAL_REV, 1'b0);
    sense.out_of_area <= 1'b1;
    wait_st(SVMS_FOLLOW, 1'b0);
    sense.out_of_area <= 1'b0;
    for (k = 4; k < 6; k++)
    begin
      u_dcl.seek(1'b0, 10'(k));
      sense[k] <= 1'b1;
      sense.speed_ok <= 1'b0;
      wait_st(SVMS_RETRACT, 1'b0);
      sense[k] <= 1'b0;
      sense.retracted <= 1'b1;
      wait_st(SVMS_UNLOADED, 1'b0);
      sense.retracted <= 1'b0;
      sense.cyl_pulse <= 1'b1;
      u_dcl.rd(`SVMS_ADDR_COUNT, v);
      chk(v, 16'(k));
      sense.cyl_pulse <= 1'b0;
      sense.speed_ok <= 1'b1;
      wait_st(SVMS_FOLLOW, 1'b0);
    end
    close_out();
  end
endmodule
